//--- include/dpram_pkg.sv
// package of timing constants and enumerations for the dual-port memory port controller
package dpram_pkg;
   // clock period in picoseconds (125 MHz)
   localparam int CLK_PS = 8000;
   // write pulse width, ns (least)
   localparam int T_WRITE_PULSE_NS = 20;
   // output-off delay after write enable, ns
   localparam int T_OUT_OFF_NS = 15;
   // data set-up to end of write, ns (least)
   localparam int T_DATA_SETUP_NS = 15;
   // write hold after busy release, ns (least)
   localparam int T_HOLD_BUSY_NS = 17;
   // semaphore write to read time, ns (least)
   localparam int T_SEM_W2R_NS = 5;
   // read data delay from access start, ns (longest wait the host allows)
   localparam int T_READ_NS = 25;
   // busy release to valid data, ns
   localparam int T_BUSY_DATA_NS = 30;
   // least times rounded up to cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction : cyc_up
   localparam int WP_CYC = cyc_up(T_WRITE_PULSE_NS);
   localparam int WPOE_CYC = cyc_up(T_OUT_OFF_NS + T_DATA_SETUP_NS);
   localparam int WH_CYC = cyc_up(T_HOLD_BUSY_NS);
   localparam int SW2R_CYC = cyc_up(T_SEM_W2R_NS);
   localparam int RD_CYC = cyc_up(T_READ_NS);
   localparam int BD_CYC = cyc_up(T_BUSY_DATA_NS);
   localparam int CNT_W = 4;
   // host command codes
   localparam logic [1:0] CMD_MEM_RD = 2'h0;
   localparam logic [1:0] CMD_MEM_WR = 2'h1;
   localparam logic [1:0] CMD_SEM_RD = 2'h2;
   localparam logic [1:0] CMD_SEM_WR = 2'h3;
   // controller states
   typedef enum logic [2:0] {
      DP_IDLE,
      DP_SETUP,
      DP_PULSE,
      DP_HOLD,
      DP_READ,
      DP_RECOV
   } dp_state_t;
endpackage : dpram_pkg

//--- logic/dp_host.sv
// host-side controller driving one port of an asynchronous dual-port memory
//
// Functional notes
// RULE_01: address changes only while write strobe, select, or both byte enables are high.
// RULE_02: device writes during overlap of byte enable, select and write strobe low.
// RULE_03: host drives write data only after device outputs turned off.
// RULE_04: device keeps outputs off when select falls with or after strobe.
// RULE_05: strobe pulse is max of pulse width or off-delay plus set-up when output enabled.
// RULE_06: memory or semaphore select condition holds through the whole access.
// RULE_07: semaphore read returns flag on every data pin.
// RULE_08: select stays high through semaphore write and read-back.
// RULE_09: near-simultaneous semaphore requests may be granted to either side.
// RULE_10: master asserts busy on address match, releases when match ends.
// RULE_11: master asserts busy after select falls on match, releases after select rises.
// RULE_12: earlier port wins arbitration given priority set-up lead.
// RULE_13: slave busy input inhibits writes; presented no later than write start.
// RULE_14: host holds write asserted at least write-hold time after busy release.
// RULE_15: written data reaches opposite port within port-to-port limits.
// RULE_16: blocked reader sees valid data within busy-release-to-data limit.
// RULE_17: losing port's write is blocked until its busy returns high.
// RULE_18: semaphore writes are deterministic only if ends are a window apart.
// RULE_19: busy asserted only on the losing port.
// RULE_20: left and right ports behave identically.
`timescale 1ns/1ps
module dp_host
   import dpram_pkg::*;
#(
   parameter int ADDR_W = 13,
   parameter int DATA_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // user command port
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_wdata,
   input wire logic [1:0] cmd_byte_en,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   // memory port pins
   output logic [ADDR_W-1:0] mem_addr,
   output logic chip_select_n,
   output logic read_write_n,
   output logic output_enable_n,
   output logic upper_byte_enable_n,
   output logic lower_byte_enable_n,
   output logic semaphore_select_n,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   input wire logic busy_n
);
   typedef struct packed {
      dp_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [1:0] op;
      logic [ADDR_W-1:0] addr;
      logic cs_n;
      logic rw_n;
      logic oe_n;
      logic ub_n;
      logic lb_n;
      logic sem_n;
      logic [DATA_W-1:0] dout;
      logic doe;
      logic rdy;
      logic rv;
      logic [DATA_W-1:0] rd;
   } dp_host_state_t;

   dp_host_state_t s_q, s_d;
   logic is_wr, is_sem;
   assign is_wr = s_q.op[0];
   assign is_sem = s_q.op[1];
   // byte enables captured with the command, read by the sequencer below
   logic [1:0] cmd_en_q;

   // next-state logic for the port sequencer
   always_comb begin
      s_d = s_q;
      s_d.rv = 1'b0;
      unique case (s_q.st)
         DP_IDLE: begin
            s_d.rdy = 1'b1;
            if (cmd_valid && s_q.rdy) begin
               // address is moved only while every strobe is high [RULE_01]
               s_d.rdy = 1'b0;
               s_d.op = cmd_op;
               s_d.addr = cmd_addr;
               s_d.dout = cmd_wdata;
               s_d.st = DP_SETUP;
            end
         end
         DP_SETUP: begin
            // memory: select and the requested byte enables low; semaphore: select and byte enables high [RULE_06] [RULE_08]
            s_d.sem_n = ~is_sem;
            s_d.cs_n = is_sem;
            s_d.ub_n = is_sem | ~cmd_en_q[1];
            s_d.lb_n = is_sem | ~cmd_en_q[0];
            // output enable kept high on writes so the short pulse suffices [RULE_05]
            s_d.oe_n = is_wr;
            // strobe falls with select, so device outputs stay off [RULE_04] [RULE_03]
            s_d.rw_n = ~is_wr;
            s_d.doe = is_wr;
            s_d.cnt = is_wr ? CNT_W'(WP_CYC) : CNT_W'(RD_CYC);
            s_d.st = is_wr ? DP_PULSE : DP_READ;
         end
         DP_PULSE: begin
            // busy low blocks a memory write; its pulse counts only once busy is high [RULE_13] [RULE_17]
            if (!busy_n && !is_sem) begin
               s_d.cnt = CNT_W'(WH_CYC);
            end else if (s_q.cnt > CNT_W'(1)) begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end else begin
               // end of write: strobe rises, hold time after busy met [RULE_14] [RULE_02]
               s_d.rw_n = 1'b1;
               s_d.cs_n = 1'b1;
               s_d.ub_n = 1'b1;
               s_d.lb_n = 1'b1;
               s_d.sem_n = 1'b1;
               s_d.st = DP_HOLD;
            end
         end
         DP_HOLD: begin
            // data held one cycle past the write end, then released
            s_d.doe = 1'b0;
            s_d.cnt = CNT_W'(SW2R_CYC);
            s_d.rv = 1'b1;
            s_d.st = DP_RECOV;
         end
         DP_READ: begin
            // a blocked reader waits the busy-to-data limit after release [RULE_16]
            if (!busy_n && !is_sem) begin
               s_d.cnt = CNT_W'(BD_CYC);
            end else if (s_q.cnt > CNT_W'(1)) begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end else begin
               // semaphore flag appears on every data bit; bit 0 taken [RULE_07]
               s_d.rd = is_sem ? {DATA_W{data_in[0]}} : data_in;
               s_d.rv = 1'b1;
               s_d.cs_n = 1'b1;
               s_d.ub_n = 1'b1;
               s_d.lb_n = 1'b1;
               s_d.sem_n = 1'b1;
               s_d.oe_n = 1'b1;
               s_d.cnt = CNT_W'(SW2R_CYC);
               s_d.st = DP_RECOV;
            end
         end
         DP_RECOV: begin
            // recovery gap keeps semaphore write-to-read spacing [RULE_18]
            if (s_q.cnt > CNT_W'(1)) begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end else begin
               s_d.rdy = 1'b1;
               s_d.st = DP_IDLE;
            end
         end
         default: s_d.st = DP_IDLE;
      endcase
   end

   // byte enable capture at command take
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_en_q <= 2'h0;
      end else if (s_q.st == DP_IDLE && cmd_valid && s_q.rdy) begin
         cmd_en_q <= cmd_byte_en;
      end
   end

   // state register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.st <= DP_IDLE;
         s_q.cs_n <= 1'b1;
         s_q.rw_n <= 1'b1;
         s_q.oe_n <= 1'b1;
         s_q.ub_n <= 1'b1;
         s_q.lb_n <= 1'b1;
         s_q.sem_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign cmd_ready = s_q.rdy;
   assign rsp_valid = s_q.rv;
   assign rsp_rdata = s_q.rd;
   assign mem_addr = s_q.addr;
   assign chip_select_n = s_q.cs_n;
   assign read_write_n = s_q.rw_n;
   assign output_enable_n = s_q.oe_n;
   assign upper_byte_enable_n = s_q.ub_n;
   assign lower_byte_enable_n = s_q.lb_n;
   assign semaphore_select_n = s_q.sem_n;
   assign data_out = s_q.dout;
   assign data_oe = s_q.doe;

   // address stable while write strobe and select are both low
   chk_addr_stable: assert property (@(posedge clk) disable iff (sys_rst)
      (!read_write_n && !chip_select_n) |=> $stable(mem_addr))
      else $error("address moved during write"); // [RULE_01]
   // write data driven only while output enable high
   chk_data_oe_off: assert property (@(posedge clk) disable iff (sys_rst)
      data_oe |-> output_enable_n)
      else $error("data driven against device outputs"); // [RULE_03]
   // semaphore access keeps select high
   chk_sem_sel: assert property (@(posedge clk) disable iff (sys_rst)
      !semaphore_select_n |-> chip_select_n)
      else $error("semaphore with select low"); // [RULE_06]
   // write pulse lasts at least the pulse count
   chk_pulse_width: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(read_write_n) |-> !read_write_n [*3])
      else $error("write pulse too short"); // [RULE_05]
   // strobe never rises while busy low on memory write
   chk_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (!read_write_n && !chip_select_n && !busy_n) |=> !read_write_n)
      else $error("write ended during busy"); // [RULE_17]
   // strobe held past busy release
   chk_hold_after: assert property (@(posedge clk) disable iff (sys_rst)
      (!read_write_n && $rose(busy_n)) |-> !read_write_n [*3])
      else $error("hold after busy too short"); // [RULE_14]
   // every response lasts a single cycle
   chk_rsp_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      rsp_valid |=> !rsp_valid)
      else $error("response longer than a cycle"); // [RULE_02]
   // semaphore read returns uniform word
   chk_sem_word: assert property (@(posedge clk) disable iff (sys_rst)
      (rsp_valid && s_q.op == CMD_SEM_RD) |->
         ((rsp_rdata == '0 || rsp_rdata == '1) && !$past(semaphore_select_n)))
      else $error("semaphore word not uniform"); // [RULE_07]
   cov_mem_wr: cover property (@(posedge clk) $fell(read_write_n) && semaphore_select_n);
   cov_sem_wr: cover property (@(posedge clk) $fell(read_write_n) && !semaphore_select_n);
   cov_busy_wait: cover property (@(posedge clk) !read_write_n && !busy_n);
endmodule : dp_host

//--- testbench/dp_dev_model.sv
// device model of one memory port: array, semaphore flag, pin checks
`timescale 1ns/1ps
module dp_dev_model
   import dpram_pkg::*;
(
   // clock
   input wire logic clk,
   // pins from the host, and the busy flag driven by the bench
   input wire logic [12:0] mem_addr,
   input wire logic chip_select_n,
   input wire logic read_write_n,
   input wire logic output_enable_n,
   input wire logic upper_byte_enable_n,
   input wire logic lower_byte_enable_n,
   input wire logic semaphore_select_n,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   input wire logic busy_n,
   // resolved data wire and host fault count
   output logic [15:0] data_in,
   output int n_viol
);
   logic [15:0] mem [0:8191];
   logic [15:0] last_q = 16'h0000;
   logic [12:0] addr_q;
   logic flag_q = 1'b1;
   logic both_off, memacc, semacc, drv;
   // access decode, same for either port
   assign both_off = upper_byte_enable_n && lower_byte_enable_n;
   assign memacc = !chip_select_n && !both_off && semaphore_select_n;
   assign semacc = !semaphore_select_n && (chip_select_n || both_off);
   // drive only on reads with output enable low, never while the strobe is low
   assign drv = (memacc || semacc) && read_write_n && !output_enable_n;
   // wire level; flag on every pin; released wire toggles
   always_comb begin
      if (data_oe) data_in = data_out;
      else if (drv && memacc) data_in = mem[mem_addr];
      else if (drv) data_in = {16{flag_q}};
      else data_in = ~last_q;
   end
   // host fault count, handed out as a port
   int viol_q = 0;
   assign n_viol = viol_q;
   // memory writes only in the overlap and not while blocked; the flag write ignores busy
   always @(posedge clk) begin
      last_q <= data_in;
      addr_q <= mem_addr;
      if (memacc && !read_write_n && busy_n && data_oe) begin
         if (!upper_byte_enable_n) mem[mem_addr][15:8] <= data_out[15:8];
         if (!lower_byte_enable_n) mem[mem_addr][7:0] <= data_out[7:0];
      end
      // single requester: the flag takes the written value
      if (semacc && !read_write_n && data_oe) flag_q <= data_out[0];
      // host faults: moving address, pin clash, mixed select
      if (addr_q !== mem_addr && !read_write_n && !chip_select_n && !both_off) viol_q++;
      if (data_oe && drv) viol_q++;
      if (!semaphore_select_n && !chip_select_n && !both_off) viol_q++;
   end
endmodule : dp_dev_model

//--- testbench/dp_host_bench.sv
// self-checking bench for the dual-port memory host controller
`timescale 1ns/1ps
module dp_host_bench
   import dpram_pkg::*;
;
   logic clk, sys_rst, cmd_valid, cmd_ready, rsp_valid, data_oe, busy_n;
   logic [1:0] cmd_op, cmd_byte_en;
   logic [12:0] cmd_addr, mem_addr;
   logic [15:0] cmd_wdata, rsp_rdata, data_in, data_out, rd;
   logic chip_select_n, read_write_n, output_enable_n, upper_byte_enable_n;
   logic lower_byte_enable_n, semaphore_select_n;
   int n_viol, n_errors = 0, check_count = 0, cyc = 0, low_cyc = 0, pulse = 0;
   int since = 0, hold = 0, n;
   dp_host dut (.clk, .sys_rst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata,
      .cmd_byte_en, .cmd_ready, .rsp_valid, .rsp_rdata, .mem_addr, .chip_select_n,
      .read_write_n, .output_enable_n, .upper_byte_enable_n, .lower_byte_enable_n,
      .semaphore_select_n, .data_in, .data_out, .data_oe, .busy_n);
   dp_dev_model dev (.clk, .mem_addr, .chip_select_n, .read_write_n,
      .output_enable_n, .upper_byte_enable_n, .lower_byte_enable_n,
      .semaphore_select_n, .data_out, .data_oe, .busy_n, .data_in, .n_viol);
   // clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : final_report
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
      end
   endtask : check
   // strobe length, hold after busy release, run ceiling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      low_cyc <= read_write_n ? 0 : low_cyc + 1;
      since <= busy_n ? since + 1 : 0;
      if (read_write_n && low_cyc > 0) pulse <= low_cyc;
      if (read_write_n && low_cyc > 0) hold <= since;
      if (cyc == 3000) begin
         n_errors++;
         final_report();
      end
   end
   // one command from offer to response, called at a clock edge
   task automatic do_cmd(input logic [1:0] op, input logic [12:0] a, input logic [15:0] d,
         input logic [1:0] be);
      n = 0;
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_byte_en <= be;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 60);
      rd = rsp_rdata;
      check(16'(n < 60), 16'h1, "no response");
   endtask : do_cmd
   // byte-lane writes, back-to-back, top address
   task automatic t_mem();
      do_cmd(CMD_MEM_WR, 13'h0005, 16'hA5C3, 2'h3);
      check(16'(pulse >= WP_CYC), 16'h1, "short pulse");
      do_cmd(CMD_MEM_WR, 13'h0005, 16'h1E77, 2'h2);
      do_cmd(CMD_MEM_WR, 13'h0005, 16'h00FF, 2'h1);
      do_cmd(CMD_MEM_WR, 13'h1FFF, 16'hBEEF, 2'h3);
      do_cmd(CMD_MEM_RD, 13'h0005, 16'h0000, 2'h3);
      check(rd, 16'h1EFF, "lanes");
      do_cmd(CMD_MEM_RD, 13'h1FFF, 16'h0000, 2'h3);
      check(rd, 16'hBEEF, "top");
   endtask : t_mem
   // semaphore write then read-back for both values
   task automatic t_sem();
      for (int v = 0; v < 2; v++) begin
         do_cmd(CMD_SEM_WR, 13'h0003, 16'(v), 2'h0);
         do_cmd(CMD_SEM_RD, 13'h0003, 16'h0000, 2'h0);
         check(rd, {16{v[0]}}, "flag");
      end
   endtask : t_sem
   // write held off by busy, completes after release
   task automatic t_busy();
      // far port began first and won; busy flag shown only on this port
      busy_n <= 1'b0;
      fork
         do_cmd(CMD_MEM_WR, 13'h0100, 16'hC0DE, 2'h3);
         begin
            repeat (12) @(posedge clk);
            busy_n <= 1'b1;
         end
      join
      check(16'(n >= 12), 16'h1, "early end");
      check(16'(hold >= WH_CYC), 16'h1, "hold");
      do_cmd(CMD_MEM_RD, 13'h0100, 16'h0000, 2'h3);
      check(rd, 16'hC0DE, "blocked write");
      // reader held by the busy flag on matching address, data after release
      busy_n <= 1'b0;
      fork
         do_cmd(CMD_MEM_RD, 13'h0100, 16'h0000, 2'h3);
         begin
            repeat (8) @(posedge clk);
            busy_n <= 1'b1;
         end
      join
      check(16'(n >= 8 + BD_CYC), 16'h1, "early read");
      check(rd, 16'hC0DE, "blocked read");
   endtask : t_busy
   // main sequence
   initial begin
      sys_rst = 1'b1;
      busy_n = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_addr = 13'h0000;
      cmd_wdata = 16'h0000;
      cmd_byte_en = 2'h0;
      repeat (2) @(posedge clk);
      check({11'h0, cmd_ready, data_oe, chip_select_n, read_write_n, semaphore_select_n},
         16'h0007, "reset pins");
      sys_rst <= 1'b0;
      @(posedge clk);
      t_mem();
      t_sem();
      t_busy();
      check(16'(n_viol), 16'h0, "pin faults");
      final_report();
   end
endmodule : dp_host_bench
